/* File: rtl/tcm_pkg.sv */
// Package for the 8-bit timer compare output unit with Normal and clear-on-match modes.
// Assumes a single system clock; the timer clock is a one-cycle enable derived from it.
package tcm_pkg;

    // Register offsets on the plain register port.
    localparam logic [3:0] TCM_OFF_CONTROL_A  = 4'h0;
    localparam logic [3:0] TCM_OFF_CONTROL_B  = 4'h1;
    localparam logic [3:0] TCM_OFF_CONTROL_C  = 4'h2;
    localparam logic [3:0] TCM_OFF_COUNT      = 4'h3;
    localparam logic [3:0] TCM_OFF_COMPARE_A  = 4'h4;
    localparam logic [3:0] TCM_OFF_COMPARE_B  = 4'h5;
    localparam logic [3:0] TCM_OFF_FLAGS      = 4'h6;
    localparam logic [3:0] TCM_OFF_PORT       = 4'h7;

    // Field positions.
    localparam int TCM_CA_MODE_A_LSB = 6;   // compare_output_mode_a [7:6]
    localparam int TCM_CA_MODE_B_LSB = 4;   // compare_output_mode_b [5:4]
    localparam int TCM_CA_WGM_LSB    = 0;   // waveform_mode [1:0]
    localparam int TCM_CB_WGM2_BIT   = 3;   // waveform_mode [2]
    localparam int TCM_CB_CS_LSB     = 0;   // clock_select_field [2:0]
    localparam int TCM_CC_FOC_A_BIT  = 7;
    localparam int TCM_CC_FOC_B_BIT  = 6;
    localparam int TCM_FL_OVF_BIT    = 0;
    localparam int TCM_FL_CMPA_BIT   = 1;
    localparam int TCM_FL_CMPB_BIT   = 2;
    localparam int TCM_PT_DIR_A_BIT  = 0;
    localparam int TCM_PT_DIR_B_BIT  = 1;
    localparam int TCM_PT_OUT_A_BIT  = 2;
    localparam int TCM_PT_OUT_B_BIT  = 3;

    // Reset values.
    localparam logic [7:0] TCM_RST_BYTE = 8'h00;
    localparam logic       TCM_RST_OC   = 1'b0;

    // Count limits.
    localparam logic [7:0] TCM_MAX    = 8'hff;
    localparam logic [7:0] TCM_BOTTOM = 8'h00;

    // Prescale taps in system clock cycles.
    localparam logic [9:0] TCM_DIV_8    = 10'h007;
    localparam logic [9:0] TCM_DIV_64   = 10'h03f;
    localparam logic [9:0] TCM_DIV_256  = 10'h0ff;
    localparam logic [9:0] TCM_DIV_1024 = 10'h3ff;

    // Waveform modes of interest.
    localparam logic [2:0] TCM_WGM_NORMAL = 3'h0;
    localparam logic [2:0] TCM_WGM_CLEAR_ON_MATCH = 3'h2;

    // Compare output actions in non-PWM modes.
    typedef enum logic [1:0] {
        TCM_COM_NONE   = 2'b00,
        TCM_COM_TOGGLE = 2'b01,
        TCM_COM_CLEAR  = 2'b10,
        TCM_COM_SET    = 2'b11
    } tcm_com_e;

    // Port pin bundle for one channel.
    typedef struct packed {
        logic out;
        logic oe;
    } tcm_pin_s;

endpackage

/* File: rtl/tcm_timer.sv */
// 8-bit timer with Normal and clear-on-match modes, compare flags and the pin override.
// Assumes synchronous register strobes, one at a time, and port pins driven outside.
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module tcm_timer
    import tcm_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       ovf_ack,
    input  wire logic       cmpa_ack,
    input  wire logic       cmpb_ack,
    output logic            ovf_irq,
    output logic            cmpa_irq,
    output logic            cmpb_irq,
    output tcm_pin_s        pin_a,
    output tcm_pin_s        pin_b
);

    logic [7:0] timer_control_a_reg;
    logic [7:0] timer_control_b_reg;
    logic [7:0] count_value_reg;
    logic [7:0] compare_value_a_reg;
    logic [7:0] compare_value_b_reg;
    logic [3:0] port_reg;
    logic       overflow_flag_reg;
    logic       compare_a_flag_reg;
    logic       compare_b_flag_reg;
    logic       compare_output_a_reg;
    logic       compare_output_b_reg;
    logic       block_reg;
    logic       pend_a_reg;
    logic       pend_b_reg;
    logic [9:0] presc_reg;
    logic       tick;
    logic [2:0] waveform_mode;
    logic [2:0] clock_select_field;
    logic [1:0] compare_output_mode_a;
    logic [1:0] compare_output_mode_b;
    logic       non_pwm;
    logic       match_a;
    logic       match_b;
    logic       wr_count;
    logic       wr_ctl_c;
    logic       wr_flags;
    logic [7:0] count_next;

    // Overview of the timing model.
    // Everything in this block runs on the single system clock. The timer
    // clock is not a clock at all but the one-cycle enable called tick, so
    // no signal here ever crosses from one clock domain to another.
    // A tick comes every cycle at the fastest clock select setting, and once
    // every 8, 64, 256 or 1024 cycles at the slower settings.
    // The divider behind the tick runs freely and is never restarted when the
    // clock select field changes. The first tick after a change may therefore
    // come early; only reset restarts the divider, so stopping the timer and
    // writing the counter do not make the first divided period exact.

    // Counting.
    // The counter only ever counts up. In Normal mode it rolls over from the
    // top of its range to zero and carries on. In clear-on-match mode it is
    // cleared on the tick at which it equals compare value A, which makes that
    // value the top of the sequence.
    // Waveform modes that this block does not support count like Normal mode.
    // This keeps the counter well defined whatever software writes, at the
    // cost of silently accepting a mode that has no waveform behind it.
    // The compare output mode fields never reach the counting logic.

    // Compare value A.
    // Compare value A is used directly by the comparator, with no shadow copy.
    // A write that moves the top below the present count lets the counter run
    // past it, through the rollover, and match only on the way up again.
    // The long excursion is the price of a compare value that acts at once.

    // Matches and flags.
    // A match is seen on the tick at which the count equals the compare value.
    // It acts on the compare output bit at that very tick, but it sets the
    // compare flag only at the following tick, which is why the pending bits
    // exist. Software that polls the flag sees it one timer period late.
    // Every flag that hardware sets and software clears gives priority to the
    // set. A clear that collides with a new event is lost rather than the event.
    // The overflow flag is set only when the count rolls over from the top of
    // its range, never when clear-on-match mode clears it at a compare value A below the top.

    // Counter writes.
    // A write to the counter always wins over counting and clearing. It also
    // blocks every match until the next tick, even while the timer is stopped.
    // This lets software load the counter and a compare value with the same
    // number without a spurious match when the timer starts. The hazard is the
    // reverse case: writing the count that is about to match loses that match.

    // Forced compare.
    // The force strobes are write-only and act in the cycle of the write. They
    // run the same action function as a real match but touch neither the flags
    // nor the counter. They are ignored in modes that are not plain counting
    // modes, where a forced edge would spoil the waveform.

    // Pin override.
    // While a compare output mode field is nonzero, the compare output bit
    // replaces the port output bit on that pin. The direction still comes from
    // the port direction bit alone, so the waveform is invisible until
    // software turns the pin into an output. Setting the compare output bit
    // first, with a forced action, gives the pin a known starting level.
    // The override does not look at the waveform mode at all.
    // The compare output bits keep their value across waveform mode changes
    // and change only on a match, a forced action or reset.

    // Register port.
    // Writes take effect at the edge that samples the write strobe. Read data
    // appear in the cycle after the read strobe and are zero in every other
    // cycle, so the data lines can be wired into an OR tree with other slaves.
    // Unmapped offsets read as zero and ignore writes.
    // The control byte C has no storage; reading it returns zero.

    // Applies one non-PWM compare action to a compare output bit.
    function automatic logic oc_action(input logic [1:0] mode, input logic cur);
        case (mode)
            TCM_COM_TOGGLE: oc_action = ~cur;
            TCM_COM_CLEAR:  oc_action = 1'b0;
            TCM_COM_SET:    oc_action = 1'b1;
            default:        oc_action = cur;
        endcase
    endfunction

    // Field decode.
    assign waveform_mode = {timer_control_b_reg[TCM_CB_WGM2_BIT],
                            timer_control_a_reg[TCM_CA_WGM_LSB +: 2]};
    assign clock_select_field    = timer_control_b_reg[TCM_CB_CS_LSB +: 3];
    assign compare_output_mode_a = timer_control_a_reg[TCM_CA_MODE_A_LSB +: 2];
    assign compare_output_mode_b = timer_control_a_reg[TCM_CA_MODE_B_LSB +: 2];
    assign non_pwm  = (waveform_mode == TCM_WGM_NORMAL) ||
                      (waveform_mode == TCM_WGM_CLEAR_ON_MATCH);
    assign wr_count = wr && (addr == TCM_OFF_COUNT);
    assign wr_ctl_c = wr && (addr == TCM_OFF_CONTROL_C);
    assign wr_flags = wr && (addr == TCM_OFF_FLAGS);

    // Comparators run on live registers; compare A is unbuffered here.
    assign match_a = (count_value_reg == compare_value_a_reg) && !block_reg;
    assign match_b = (count_value_reg == compare_value_b_reg) && !block_reg;

    // Prescaler: a free-running divider gives the one-cycle timer tick.
    always_ff @(posedge clk)
    begin
        if (!rstn)
            presc_reg <= 10'h000;
        else
            presc_reg <= presc_reg + 10'h001;
    end

    // Tick selection; zero stops the timer entirely.
    always_comb
    begin
        case (clock_select_field)
            3'h1:    tick = 1'b1;
            3'h2:    tick = (presc_reg[2:0] == TCM_DIV_8[2:0]);
            3'h3:    tick = (presc_reg[5:0] == TCM_DIV_64[5:0]);
            3'h4:    tick = (presc_reg[7:0] == TCM_DIV_256[7:0]);
            3'h5:    tick = (presc_reg == TCM_DIV_1024);
            default: tick = 1'b0;
        endcase
    end

    // Next count: up only; clear at compare A in clear-on-match mode.
    always_comb
    begin
        if ((waveform_mode == TCM_WGM_CLEAR_ON_MATCH) && match_a)
            count_next = TCM_BOTTOM;
        else
            count_next = count_value_reg + 8'h01;
    end

    // Counter; a CPU write has priority over counting at any time.
    always_ff @(posedge clk)
    begin
        if (!rstn)
            count_value_reg <= TCM_RST_BYTE;
        else if (wr_count)
            count_value_reg <= wdata;
        else if (tick)
            count_value_reg <= count_next;
    end

    // Match blocking lasts until the timer tick after the write.
    always_ff @(posedge clk)
    begin
        if (!rstn)
            block_reg <= 1'b0;
        else if (wr_count)
            block_reg <= 1'b1;
        else if (tick)
            block_reg <= 1'b0;
    end

    // Control and compare registers.
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            timer_control_a_reg <= TCM_RST_BYTE;
            timer_control_b_reg <= TCM_RST_BYTE;
            compare_value_a_reg <= TCM_RST_BYTE;
            compare_value_b_reg <= TCM_RST_BYTE;
            port_reg            <= 4'h0;
        end
        else if (wr)
        begin
            case (addr)
                TCM_OFF_CONTROL_A: timer_control_a_reg <= wdata;
                TCM_OFF_CONTROL_B: timer_control_b_reg <= wdata;
                TCM_OFF_COMPARE_A: compare_value_a_reg <= wdata;
                TCM_OFF_COMPARE_B: compare_value_b_reg <= wdata;
                TCM_OFF_PORT:      port_reg            <= wdata[3:0];
                default:           port_reg            <= port_reg;
            endcase
        end
    end

    // Matches seen on a tick are held to set the flags on the next tick.
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            pend_a_reg <= 1'b0;
            pend_b_reg <= 1'b0;
        end
        else if (tick)
        begin
            pend_a_reg <= match_a;
            pend_b_reg <= match_b;
        end
    end

    // Overflow flag: set on any tick at TCM_MAX, by wrap or clear, unless the counter is written.
    // Set wins over a clear arriving in the same cycle.
    always_ff @(posedge clk)
    begin
        if (!rstn)
            overflow_flag_reg <= 1'b0;
        else if (tick && !wr_count && (count_value_reg == TCM_MAX))
            overflow_flag_reg <= 1'b1;
        else if (ovf_ack || (wr_flags && wdata[TCM_FL_OVF_BIT]))
            overflow_flag_reg <= 1'b0;
    end

    // Compare flags; a forced match never sets them.
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            compare_a_flag_reg <= 1'b0;
            compare_b_flag_reg <= 1'b0;
        end
        else
        begin
            if (tick && pend_a_reg)
                compare_a_flag_reg <= 1'b1;
            else if (cmpa_ack || (wr_flags && wdata[TCM_FL_CMPA_BIT]))
                compare_a_flag_reg <= 1'b0;
            if (tick && pend_b_reg)
                compare_b_flag_reg <= 1'b1;
            else if (cmpb_ack || (wr_flags && wdata[TCM_FL_CMPB_BIT]))
                compare_b_flag_reg <= 1'b0;
        end
    end

    // Compare output registers. The mode is read at the match itself, so a
    // newly written mode acts on the next match; force applies it at once.
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            compare_output_a_reg <= TCM_RST_OC;
            compare_output_b_reg <= TCM_RST_OC;
        end
        else
        begin
            if ((tick && match_a) ||
                (wr_ctl_c && non_pwm && wdata[TCM_CC_FOC_A_BIT]))
                compare_output_a_reg <= oc_action(compare_output_mode_a,
                                                  compare_output_a_reg);
            if ((tick && match_b) ||
                (wr_ctl_c && non_pwm && wdata[TCM_CC_FOC_B_BIT]))
                compare_output_b_reg <= oc_action(compare_output_mode_b,
                                                  compare_output_b_reg);
        end
    end

    // Pin override: independent of waveform mode; direction from port bit.
    // This block has no input capture, so the mode field reaches none.
    always_comb
    begin
        pin_a.oe  = port_reg[TCM_PT_DIR_A_BIT];
        pin_b.oe  = port_reg[TCM_PT_DIR_B_BIT];
        pin_a.out = (|compare_output_mode_a) ? compare_output_a_reg
                                             : port_reg[TCM_PT_OUT_A_BIT];
        pin_b.out = (|compare_output_mode_b) ? compare_output_b_reg
                                             : port_reg[TCM_PT_OUT_B_BIT];
    end

    assign ovf_irq  = overflow_flag_reg;
    assign cmpa_irq = compare_a_flag_reg;
    assign cmpb_irq = compare_b_flag_reg;

    // Read data one cycle after the strobe; unmapped addresses read zero.
    always_ff @(posedge clk)
    begin
        if (!rstn)
            rdata <= TCM_RST_BYTE;
        else if (rd)
        begin
            case (addr)
                TCM_OFF_CONTROL_A: rdata <= timer_control_a_reg;
                TCM_OFF_CONTROL_B: rdata <= timer_control_b_reg;
                TCM_OFF_COUNT:     rdata <= count_value_reg;
                TCM_OFF_COMPARE_A: rdata <= compare_value_a_reg;
                TCM_OFF_COMPARE_B: rdata <= compare_value_b_reg;
                TCM_OFF_FLAGS:     rdata <= {5'h00, compare_b_flag_reg,
                                             compare_a_flag_reg, overflow_flag_reg};
                TCM_OFF_PORT:      rdata <= {2'h0, compare_output_b_reg,
                                             compare_output_a_reg, port_reg};
                default:           rdata <= TCM_RST_BYTE;
            endcase
        end
        else
            rdata <= TCM_RST_BYTE;
    end

endmodule
`default_nettype wire

/* File: testbench/tcm_monitor.sv */
// Checker for the timer pin override, flags and toggle period.
// Assumes it is bound to tcm_timer and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module tcm_monitor
    import tcm_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       ovf_ack,
    input  wire tcm_pin_s   pin_a,
    input  wire tcm_pin_s   pin_b,
    input  wire logic       ovf_irq,
    input  wire logic       cmpa_irq
);
    logic [7:0] ctl_a;
    logic [7:0] ctl_b;
    logic [7:0] cmp_a;
    logic [7:0] port_sh;
    logic [7:0] gap;
    logic       prev_out;
    logic       steady;
    wire  logic chg = pin_a.out != prev_out;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Shadow copies of control A and B, compare A and the port byte, taken from the write strobe.
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            ctl_a   <= 8'h00;
            ctl_b   <= 8'h00;
            cmp_a   <= 8'h00;
            port_sh <= 8'h00;
        end
        else if (wr)
        begin
            if (addr == TCM_OFF_CONTROL_A) ctl_a <= wdata;
            if (addr == TCM_OFF_CONTROL_B) ctl_b <= wdata;
            if (addr == TCM_OFF_COMPARE_A) cmp_a <= wdata;
            if (addr == TCM_OFF_PORT) port_sh <= wdata;
        end
    end
    // Gap between pin changes; any write clears steady until the next change, as it may shift the phase.
    always_ff @(posedge clk)
    begin
        prev_out <= pin_a.out;
        gap      <= chg ? 8'h00 : gap + 8'h01;
        if (!rstn || wr) steady <= 1'b0;
        else if (chg) steady <= 1'b1;
    end
    sequence s_match_toggle;
        ctl_a[7:6] == TCM_COM_TOGGLE && {ctl_b[3], ctl_a[1:0]} == TCM_WGM_CLEAR_ON_MATCH &&
        ctl_b[2:0] == 3'h1;
    endsequence
    AST_OE_DIR: assert property (wr && addr == TCM_OFF_PORT |=>
        pin_a.oe == $past(wdata[TCM_PT_DIR_A_BIT]) && pin_b.oe == $past(wdata[TCM_PT_DIR_B_BIT]))
        else $error("pin enable differs from direction bit");
    AST_PORT_A: assert property (ctl_a[7:6] == 2'h0 |-> pin_a.out == port_sh[2])
        else $error("pin a not from port bit");
    AST_PORT_B: assert property (ctl_a[5:4] == 2'h0 |-> pin_b.out == port_sh[3])
        else $error("pin b not from port bit");
    AST_SET_HOLD: assert property (ctl_a[7:6] == TCM_COM_SET &&
        $past(ctl_a[7:6]) == TCM_COM_SET && $past(pin_a.out) |-> pin_a.out)
        else $error("output dropped in set mode");
    AST_CLR_HOLD: assert property (ctl_a[7:6] == TCM_COM_CLEAR &&
        $past(ctl_a[7:6]) == TCM_COM_CLEAR && !$past(pin_a.out) |-> !pin_a.out)
        else $error("output rose in clear mode");
    AST_OVF_ACK: assert property (ovf_ack && ctl_b[2:0] == 3'h0 |=> !ovf_irq)
        else $error("overflow flag kept after service");
    AST_FLAG_WCLR: assert property (wr && addr == TCM_OFF_FLAGS && wdata[1] &&
        ctl_b[2:0] == 3'h0 |=> !cmpa_irq)
        else $error("compare flag kept after write of one");
    AST_STOP_OVF: assert property (ctl_b[2:0] == 3'h0 && !ovf_irq |=> !ovf_irq)
        else $error("overflow while stopped");
    AST_TOGGLE_GAP: assert property (s_match_toggle ##0 (chg && steady) |-> gap == cmp_a)
        else $error("toggle spacing wrong");
endmodule
bind tcm_timer tcm_monitor u_mon (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .ovf_ack(ovf_ack), .pin_a(pin_a), .pin_b(pin_b), .ovf_irq(ovf_irq),
    .cmpa_irq(cmpa_irq));
`default_nettype wire

/* File: testbench/tcm_pin_model.sv */
// Port pad model for the two timer pins.
// Assumes the pin bundles of tcm_timer; an undriven pad keeps changing level.
`timescale 1ns/10ps
`default_nettype none
module tcm_pin_model
    import tcm_pkg::*;
(
    input  wire logic     clk,
    input  wire tcm_pin_s pin_a,
    input  wire tcm_pin_s pin_b,
    output logic          pad_a,
    output logic          pad_b
);
    logic last_a = 1'b0;
    logic last_b = 1'b0;
    // Last level, so that a floating pad never mimics a driven one.
    // Starting at zero keeps an undriven pad from staying unknown forever.
    always @(posedge clk)
    begin
        last_a <= pad_a;
        last_b <= pad_b;
    end
    // A pad shows the timer only while its direction bit selects output.
    assign pad_a = pin_a.oe ? pin_a.out : ~last_a;
    assign pad_b = pin_b.oe ? pin_b.out : ~last_b;
endmodule
`default_nettype wire

/* File: testbench/tcm_timer_tb_top.sv */
// Testbench for tcm_timer: register tasks, pin checks and timed waveforms.
// Assumes the bound checker and the pad model beside the design.
`timescale 1ns/10ps
`default_nettype none
module tcm_timer_tb_top
    import tcm_pkg::*;
;
    logic clk = 0, rstn = 0, wr = 0, rd = 0, ovf_ack = 0, cmpa_ack = 0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rdata, v;
    logic ovf_irq, cmpa_irq, cmpb_irq, pad_a, pad_b;
    tcm_pin_s pin_a, pin_b;
    int fails = 0, tests_run = 0, n;
    logic [3:0] offs [8] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9};
    tcm_com_e mods [5] = '{TCM_COM_SET, TCM_COM_CLEAR, TCM_COM_TOGGLE, TCM_COM_NONE, TCM_COM_TOGGLE};
    logic ocx [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    tcm_timer dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .ovf_ack(ovf_ack), .cmpa_ack(cmpa_ack), .cmpb_ack(1'b0),
        .ovf_irq(ovf_irq), .cmpa_irq(cmpa_irq), .cmpb_irq(cmpb_irq), .pin_a(pin_a),
        .pin_b(pin_b));
    tcm_pin_model pads (.clk(clk), .pin_a(pin_a), .pin_b(pin_b), .pad_a(pad_a), .pad_b(pad_b));
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask
    // Counts edges until the pad changes, bounded so a stuck pin cannot hang.
    task automatic wait_chg(output int k);
        logic p;
        p = pad_a;
        k = 0;
        do
        begin
            @(posedge clk);
            #1;
            k++;
        end while (pad_a === p && k < 1000);
    endtask
    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Free-running 200 MHz clock.
    initial
    begin
        forever #2.5 clk = ~clk;
    end
    // Watchdog, far beyond the few hundred cycles the tests need.
    initial
    begin
        #100000;
        fails++;
        end_sim;
    end
    // Main sequence: reset, forced actions, override, Normal, then clear-on-match.
    initial
    begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        foreach (offs[i])
        begin
            rd_reg(offs[i], v);
            check("reset read", v, 8'h00);
        end
        check("reset pins", {4'h0, pin_a, pin_b}, 8'h00);
        for (int i = 0; i < 5; i++)
        begin
            wr_reg(TCM_OFF_CONTROL_A, {mods[i], 6'h00});
            wr_reg(TCM_OFF_CONTROL_C, 8'h80);
            rd_reg(TCM_OFF_PORT, v);
            check("forced oc a", v, {3'h0, ocx[i], 4'h0});
        end
        check("flag after force", cmpa_irq, 1'b0);
        check("enable while input", pin_a.oe, 1'b0);
        wr_reg(TCM_OFF_PORT, 8'h0d);
        check("override a", pin_a.out, 1'b0);
        check("pad a", pad_a, 1'b0);
        check("port b", pin_b.out, 1'b1);
        wr_reg(TCM_OFF_CONTROL_A, 8'h02);
        check("port a in clear mode", pin_a.out, 1'b1);
        wr_reg(TCM_OFF_CONTROL_A, 8'h00);
        wr_reg(TCM_OFF_COUNT, 8'hfd);
        repeat (5) @(posedge clk);
        rd_reg(TCM_OFF_COUNT, v);
        check("stopped count", v, 8'hfd);
        check("no overflow yet", ovf_irq, 1'b0);
        wr_reg(TCM_OFF_CONTROL_B, 8'h01);
        repeat (8) @(posedge clk);
        wr_reg(TCM_OFF_CONTROL_B, 8'h00);
        check("overflow", ovf_irq, 1'b1);
        rd_reg(TCM_OFF_COUNT, v);
        check("wrapped count", v < 8'h10, 1'b1);
        @(posedge clk) ovf_ack <= 1'b1;
        @(posedge clk) ovf_ack <= 1'b0;
        #1;
        check("overflow serviced", ovf_irq, 1'b0);
        wr_reg(TCM_OFF_COMPARE_A, 8'h03);
        wr_reg(TCM_OFF_CONTROL_A, 8'h42);
        wr_reg(TCM_OFF_CONTROL_B, 8'h01);
        wait_chg(n);
        for (int i = 0; i < 3; i++)
        begin
            wait_chg(n);
            check("half period", n[7:0], 8'h04);
        end
        for (int i = 0; i < 4; i++)
        begin
            rd_reg(TCM_OFF_COUNT, v);
            check("count below top", v <= 8'h03, 1'b1);
        end
        check("compare a flag", cmpa_irq, 1'b1);
        wr_reg(TCM_OFF_CONTROL_B, 8'h00);
        wr_reg(TCM_OFF_FLAGS, 8'h02);
        check("flag write clear", cmpa_irq, 1'b0);
        wr_reg(TCM_OFF_COUNT, 8'h0a);
        wr_reg(TCM_OFF_COMPARE_A, 8'h05);
        wr_reg(TCM_OFF_FLAGS, 8'h07);
        wr_reg(TCM_OFF_CONTROL_B, 8'h01);
        repeat (100) @(posedge clk);
        #1;
        check("missed match", cmpa_irq, 1'b0);
        check("no early overflow", ovf_irq, 1'b0);
        repeat (160) @(posedge clk);
        #1;
        check("overflow in ctc", ovf_irq, 1'b1);
        check("match after wrap", cmpa_irq, 1'b1);
        check("compare b flag", cmpb_irq, 1'b1);
        wr_reg(TCM_OFF_CONTROL_B, 8'h00);
        @(posedge clk) cmpa_ack <= 1'b1;
        @(posedge clk) cmpa_ack <= 1'b0;
        #1;
        check("compare serviced", cmpa_irq, 1'b0);
        end_sim;
    end
endmodule
`default_nettype wire
